// file: dv/core_hw_config_regs_props.sv
// Port-level checks for the core hardware configuration register bank.
`timescale 1ns/1ps
module core_hw_config_regs_props
(
  // Clock, resets and pins.
  input wire        clk,
  input wire        arst_n,
  input wire        hard_reset_n,
  input wire        sysclk,
  input wire        little_endian_mode_bit,
  input wire [6:0]  pll_cfg,
  // Register bus.
  input wire [3:0]  s_axi_awaddr,
  input wire [3:0]  s_axi_araddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire [1:0]  s_axi_bresp,
  input wire [1:0]  s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  // Configuration outputs.
  input wire        clk_out,
  input wire        true_le_active,
  input wire        fetch_burst_ext_enable,
  input wire        four_state_coherency_enable,
  input wire        fetch_cancel_ext_enable,
  input wire        bus_queue_sharing_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_le_gate: assert property (true_le_active |-> $past(little_endian_mode_bit))
    else $error("little-endian active without the mode bit");
  chk_pll_mirror: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h0 |=>
    s_axi_rdata == {25'h0, $past(pll_cfg)}) else $error("pll mirror read wrong");
  chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h3 |=>
    s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  chk_wr_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr[3:2] == 2'h3 |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2) else $error("unmapped write");
  chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready && s_axi_rvalid)
    else $error("read answer late");
  chk_hrst_clear: assert property ((!hard_reset_n)[*3] |-> !fetch_burst_ext_enable && !fetch_cancel_ext_enable
    && !four_state_coherency_enable && !bus_queue_sharing_enable) else $error("feature set in hard reset");
  chk_hrst_single: assert property ((!hard_reset_n)[*3] ##0 clk_out |=> !clk_out)
    else $error("clock pulse too long in hard reset");
  chk_hrst_follow: assert property ((!hard_reset_n)[*3] ##0 $rose(sysclk) |-> ##[0:2] clk_out)
    else $error("no clock pulse for bus clock rise");
endmodule

bind core_hw_config_regs core_hw_config_regs_props core_hw_config_regs_props_i
(
  .clk(clk), .arst_n(arst_n), .hard_reset_n(hard_reset_n), .sysclk(sysclk), .pll_cfg(pll_cfg),
  .little_endian_mode_bit(little_endian_mode_bit), .s_axi_awaddr(s_axi_awaddr), .s_axi_araddr(s_axi_araddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .clk_out(clk_out), .true_le_active(true_le_active),
  .fetch_burst_ext_enable(fetch_burst_ext_enable), .four_state_coherency_enable(four_state_coherency_enable),
  .fetch_cancel_ext_enable(fetch_cancel_ext_enable), .bus_queue_sharing_enable(bus_queue_sharing_enable)
);

// file: dv/tb_core_hw_config_regs.sv
// Self-checking bench for the core hardware configuration register bank.
`timescale 1ns/1ps
module tb_core_hw_config_regs;
  reg         clk = 1'h0, arst_n = 1'h0, hard_reset_n = 1'h0, tle_strap = 1'h1, sysclk = 1'h0, le_mode = 1'h0;
  reg  [6:0]  pll_cfg = 7'h55;
  reg  [3:0]  awaddr = 4'h0, araddr = 4'h0;
  reg  [31:0] wdata = 32'h0, rd;
  reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  wire        awready, wready, bvalid, arready, rvalid, clk_out, tle_on;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [3:0]  feat;
  integer     n_errors = 0, checks = 0, cnt, k, e;

  core_hw_config_regs core_hw_config_regs_i
  (
    .clk(clk), .arst_n(arst_n), .hard_reset_n(hard_reset_n), .tle_strap(tle_strap), .pll_cfg(pll_cfg),
    .sysclk(sysclk), .little_endian_mode_bit(le_mode), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .clk_out(clk_out), .true_le_active(tle_on), .fetch_burst_ext_enable(feat[0]),
    .four_state_coherency_enable(feat[1]), .fetch_cancel_ext_enable(feat[2]), .bus_queue_sharing_enable(feat[3])
  );

  initial
  forever #5 clk = ~clk;

  // A slow bus clock keeps its rises apart, so each tick on clk_out is countable.
  initial
  forever
  begin
    repeat (3) @(posedge clk);
    sysclk <= ~sysclk;
  end

  task cmp(input [31:0] s, input [31:0] x, input string nm);
    begin
      checks = checks + 1;
      if (s !== x)
      begin
        n_errors = n_errors + 1;
        $display("BAD %s expected %h seen %h", nm, x, s);
      end
    end
  endtask

  task wr(input [3:0] a, input [31:0] d, input [1:0] er);
    reg aw_d, w_d;
    begin
      aw_d = 1'h0;
      w_d = 1'h0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(aw_d && w_d))
      begin
        @(posedge clk);
        if (awready === 1'h1) awvalid <= 1'h0;
        if (wready === 1'h1) wvalid <= 1'h0;
        aw_d = aw_d | (awready === 1'h1);
        w_d = w_d | (wready === 1'h1);
      end
      while (bvalid !== 1'h1) @(posedge clk);
      bready <= 1'h0;
      cmp(bresp, er, "bresp");
    end
  endtask

  task rd_reg(input [3:0] a, input [1:0] er);
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      @(posedge clk);
      while (arready !== 1'h1) @(posedge clk);
      arvalid <= 1'h0;
      while (rvalid !== 1'h1) @(posedge clk);
      rd = rdata;
      rready <= 1'h0;
      cmp(rresp, er, "rresp");
    end
  endtask

  task count(input integer n);
    begin
      cnt = 0;
      repeat (n) @(posedge clk) cnt = cnt + (clk_out === 1'h1);
    end
  endtask

  task close_out;
    begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  initial
  begin
    #100000;
    n_errors = n_errors + 1;
    close_out;
  end

  initial
  begin
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    count(60);
    cmp(cnt >= 9 && cnt <= 11, 1, "hreset ticks");
    hard_reset_n <= 1'h1;
    repeat (3) @(posedge clk);
    rd_reg(4'h4, 2'h0);
    cmp(rd, 32'h10, "strap bit");
    cmp(tle_on, 0, "tle off");
    le_mode <= 1'h1;
    repeat (3) @(posedge clk);
    cmp(tle_on, 1, "tle on");
    for (k = 0; k < 4; k = k + 1)
    begin
      e = 32'h10 | (32'h1 << ((k == 0) ? 5 : k + 6));
      wr(4'h4, e, 2'h0);
      rd_reg(4'h4, 2'h0);
      cmp(rd, e, "feature reg");
      cmp(feat, 4'h1 << k, "feature out");
    end
    for (k = 0; k < 2; k = k + 1)
    begin
      pll_cfg <= k ? 7'h2a : 7'h7f;
      wr(4'h0, 32'hffffffff, 2'h0);
      rd_reg(4'h0, 2'h0);
      cmp(rd, k ? 32'h2a : 32'h7f, "pll mirror");
    end
    wr(4'hc, 32'hffffffff, 2'h2);
    rd_reg(4'hc, 2'h2);
    cmp(rd, 32'h0, "unmapped");
    rd_reg(4'h4, 2'h0);
    cmp(rd, 32'h210, "feature kept");
    for (k = 0; k < 4; k = k + 1)
    begin
      wr(4'h8, k, 2'h0);
      rd_reg(4'h8, 2'h0);
      cmp(rd, k, "clock select");
      e = (k == 0) ? 0 : (k == 1) ? 30 : (k == 2) ? 60 : 10;
      count(60);
      cmp(cnt >= e - (k == 3) && cnt <= e + (k == 3), 1, "clk_out ticks");
    end
    wr(4'h8, 32'h2, 2'h0);
    tle_strap <= 1'h0;
    hard_reset_n <= 1'h0;
    repeat (3) @(posedge clk);
    count(60);
    cmp(cnt >= 9 && cnt <= 11, 1, "hreset over core");
    hard_reset_n <= 1'h1;
    repeat (3) @(posedge clk);
    cmp(feat, 0, "feature cleared");
    cmp(tle_on, 1'h0, "tle gated");
    rd_reg(4'h4, 2'h0);
    cmp(rd, 32'h0, "strap low");
    rd_reg(4'h8, 2'h0);
    cmp(rd, 32'h0, "select cleared");
    close_out;
  end
endmodule

// file: rtl/clock_out_gen.v
// Clock output source selection, expressed as one tick per rising edge of the chosen clock.
`timescale 1ns/1ps
`include "core_hw_defines.vh"

module clock_out_gen
(
  // Clock and reset.
  input  wire       clk,
  input  wire       arst_n,
  // Controls.
  input  wire       hard_reset_active,
  input  wire [1:0] clock_select,
  input  wire       sysclk,
  // Output.
  output reg        clk_out
);

  // The system clock pin is sampled as a synchronous level, so its rise is a one-cycle tick.
  reg  sysclk_prev;
  reg  half_phase;
  wire bus_tick;

  assign bus_tick = sysclk & ~sysclk_prev;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sysclk_prev <= 1'b0;
      half_phase  <= 1'b0;
      clk_out     <= 1'b0;
    end
    else
    begin
      sysclk_prev <= sysclk;
      half_phase  <= ~half_phase;
      if (hard_reset_active)
      begin
        clk_out <= bus_tick;
      end
      else
      begin
        case (clock_select)
          `CLKSEL_OFF:       clk_out <= 1'b0;
          `CLKSEL_CORE_DIV2: clk_out <= half_phase;
          `CLKSEL_CORE:      clk_out <= 1'b1;
          `CLKSEL_BUS:       clk_out <= bus_tick;
          default:           clk_out <= 1'b0;
        endcase
      end
    end
  end

endmodule

// file: rtl/core_hw_config_regs.v
// Core hardware configuration register bank with an AXI4-Lite slave port.
`timescale 1ns/1ps
`include "core_hw_defines.vh"

module core_hw_config_regs
(
  // Clock and power-on reset.
  input  wire        clk,
  input  wire        arst_n,

  // Hard reset, strap and pin inputs.
  input  wire        hard_reset_n,
  input  wire        tle_strap,
  input  wire [6:0]  pll_cfg,
  input  wire        sysclk,
  input  wire        little_endian_mode_bit,

  // AXI4-Lite write address channel.
  input  wire [3:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,

  // AXI4-Lite write data channel.
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,

  // AXI4-Lite write response channel.
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,

  // AXI4-Lite read address channel.
  input  wire [3:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,

  // AXI4-Lite read data channel.
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,

  // Core configuration outputs.
  output wire        clk_out,
  output reg         true_le_active,
  output reg         fetch_burst_ext_enable,
  output reg         four_state_coherency_enable,
  output reg         fetch_cancel_ext_enable,
  output reg         bus_queue_sharing_enable
);

  // Stored configuration fields.
  reg         true_le_enable;
  reg         fetch_burst_bit;
  reg         four_state_bit;
  reg         fetch_cancel_bit;
  reg         queue_sharing_bit;
  reg         core_clock_out_select;
  reg         bus_clock_out_select;

  // Captured write request.
  reg  [3:0]  wr_addr;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;

  // Write and read decode.
  wire        wr_fire;
  wire        wr_feature;
  wire        wr_clksel;
  wire        wr_hit;
  wire        wr_feat_lo;
  wire        wr_feat_hi;
  wire        rd_fire;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;

  // Current register images.
  wire [31:0] pll_config_mirror;
  wire [31:0] core_feature_config;
  wire [31:0] hw_impl_reg_zero;

  wire        hard_reset_active;

  assign hard_reset_active = ~hard_reset_n;

  // The protection attributes are not decoded; every access is treated alike.
  // Both channels held and no response pending: the write is performed now.
  assign wr_fire    = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_feature = (wr_addr == `OFS_CORE_FEATURE_CONFIG);
  assign wr_clksel  = (wr_addr == `OFS_HW_IMPL_REG_ZERO);
  assign wr_hit     = wr_feature | wr_clksel | (wr_addr == `OFS_PLL_CONFIG_MIRROR);
  // Byte lane 0 carries bits 4, 5 and 7; byte lane 1 carries bits 8 and 9.
  assign wr_feat_lo = wr_fire & wr_feature & wr_strb[0];
  assign wr_feat_hi = wr_fire & wr_feature & wr_strb[1];
  assign rd_fire    = s_axi_arvalid & s_axi_arready;

  // The mirror is combinational from the pins, so a read returns the level at the read edge.
  assign pll_config_mirror = {{(32 - `PLL_CFG_WIDTH){1'b0}}, pll_cfg};

  // Reserved positions read as zero and ignore what is written to them.
  assign core_feature_config = {22'h0,
                                queue_sharing_bit,
                                fetch_cancel_bit,
                                four_state_bit,
                                1'b0,
                                fetch_burst_bit,
                                true_le_enable,
                                4'h0};

  assign hw_impl_reg_zero = {30'h0, core_clock_out_select, bus_clock_out_select};

  // Write address channel; it stays closed from its handshake until the response is taken.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b1;
      wr_addr       <= 4'h0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      wr_addr       <= {s_axi_awaddr[3:2], 2'b00};
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel; it may be taken before, with or after the address.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_wready <= 1'b1;
      wr_data      <= 32'h00000000;
      wr_strb      <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wr_data      <= s_axi_wdata;
      wr_strb      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; both halves must be held, so a lone address or data word never writes.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Feature fields; hard reset wins over any software write in the same cycle.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      true_le_enable    <= `RST_FEATURE_BIT;
      fetch_burst_bit   <= `RST_FEATURE_BIT;
      four_state_bit    <= `RST_FEATURE_BIT;
      fetch_cancel_bit  <= `RST_FEATURE_BIT;
      queue_sharing_bit <= `RST_FEATURE_BIT;
    end
    else if (hard_reset_active)
    begin
      // Tracking the strap throughout hard reset leaves its last level at release.
      true_le_enable    <= tle_strap;
      fetch_burst_bit   <= `RST_FEATURE_BIT;
      four_state_bit    <= `RST_FEATURE_BIT;
      fetch_cancel_bit  <= `RST_FEATURE_BIT;
      queue_sharing_bit <= `RST_FEATURE_BIT;
    end
    else
    begin
      if (wr_feat_lo)
      begin
        true_le_enable  <= wr_data[`BIT_TRUE_LE_ENABLE];
        fetch_burst_bit <= wr_data[`BIT_FETCH_BURST];
        four_state_bit  <= wr_data[`BIT_FOUR_STATE_COH];
      end
      if (wr_feat_hi)
      begin
        fetch_cancel_bit  <= wr_data[`BIT_FETCH_CANCEL];
        queue_sharing_bit <= wr_data[`BIT_QUEUE_SHARING];
      end
    end
  end

  // Clock output selects; hard reset clears them, so the pin comes back off after release.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_clock_out_select <= `RST_CLOCK_SEL;
      bus_clock_out_select  <= `RST_CLOCK_SEL;
    end
    else if (hard_reset_active)
    begin
      core_clock_out_select <= `RST_CLOCK_SEL;
      bus_clock_out_select  <= `RST_CLOCK_SEL;
    end
    else if (wr_fire && wr_clksel && wr_strb[0])
    begin
      core_clock_out_select <= wr_data[`BIT_CORE_CLOCK_SEL];
      bus_clock_out_select  <= wr_data[`BIT_BUS_CLOCK_SEL];
    end
  end

  // Read decode; the mirror register silently drops writes but answers reads normally.
  always @*
  begin
    next_rdata = 32'h00000000;
    next_rresp = `RESP_OKAY;
    case ({s_axi_araddr[3:2], 2'b00})
      `OFS_PLL_CONFIG_MIRROR:   next_rdata = pll_config_mirror;
      `OFS_CORE_FEATURE_CONFIG: next_rdata = core_feature_config;
      `OFS_HW_IMPL_REG_ZERO:    next_rdata = hw_impl_reg_zero;
      default:                  next_rresp = `RESP_SLVERR;
    endcase
  end

  // One read at a time: the address channel closes until the data is taken.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      if (rd_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= next_rresp;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Registered copies of the fields for the core; they lag the stored bits by one cycle.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      true_le_active              <= 1'b0;
      fetch_burst_ext_enable      <= 1'b0;
      four_state_coherency_enable <= 1'b0;
      fetch_cancel_ext_enable     <= 1'b0;
      bus_queue_sharing_enable    <= 1'b0;
    end
    else
    begin
      // The enable alone does nothing, since the modified little-endian mode is not offered.
      true_le_active              <= true_le_enable & little_endian_mode_bit;
      fetch_burst_ext_enable      <= fetch_burst_bit;
      four_state_coherency_enable <= four_state_bit;
      fetch_cancel_ext_enable     <= fetch_cancel_bit;
      bus_queue_sharing_enable    <= queue_sharing_bit;
    end
  end

  // The pin selection lives in its own module so the output stays a single flop.
  clock_out_gen clock_out_gen_i
  (
    .clk               (clk),
    .arst_n            (arst_n),
    .hard_reset_active (hard_reset_active),
    .clock_select      ({core_clock_out_select, bus_clock_out_select}),
    .sysclk            (sysclk),
    .clk_out           (clk_out)
  );

endmodule

// file: rtl/core_hw_defines.vh
// Constants for the core hardware configuration register bank.
// Functional notes
// - During hard reset the clock output carries a pulse per system clock rise.
// - Outside hard reset, select bits 00 off, 01 core/2, 10 core, 11 bus.
// - Seven PLL configuration bits read at bits 0 to 6, read-only.
// - Each PLL configuration bit follows its configuration input.
// - True little-endian enable bit 4 loads from the strap at hard reset release.
// - True little-endian operation only when enable and machine-state bit both set.
// - Bit 5 enables the instruction fetch burst extension.
// - Bit 7 selects four-state coherency when 1, three-state when 0.
// - Bit 8 enables the instruction fetch cancel extension.
// - Bit 9 enables bus interface queue sharing for data cache requests.
`ifndef CORE_HW_DEFINES_VH
`define CORE_HW_DEFINES_VH

// Register byte offsets.
`define OFS_PLL_CONFIG_MIRROR   4'h0
`define OFS_CORE_FEATURE_CONFIG 4'h4
`define OFS_HW_IMPL_REG_ZERO    4'h8

// Field positions of core_feature_config.
`define BIT_TRUE_LE_ENABLE      4
`define BIT_FETCH_BURST         5
`define BIT_FOUR_STATE_COH      7
`define BIT_FETCH_CANCEL        8
`define BIT_QUEUE_SHARING       9

// Field positions of hw_impl_reg_zero.
`define BIT_BUS_CLOCK_SEL       0
`define BIT_CORE_CLOCK_SEL      1

// Width of the PLL configuration field.
`define PLL_CFG_WIDTH           7

// Reset values.
`define RST_FEATURE_BIT         1'b0
`define RST_CLOCK_SEL           1'b0

// Clock output selections, {core_clock_out_select, bus_clock_out_select}.
`define CLKSEL_OFF              2'b00
`define CLKSEL_CORE_DIV2        2'b01
`define CLKSEL_CORE             2'b10
`define CLKSEL_BUS              2'b11

// Bus responses.
`define RESP_OKAY               2'b00
`define RESP_SLVERR             2'b10

`endif
